// ==== design/upfc_pkg.sv ====
package upfc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int DATA_W = 8;
  localparam int RX_DEPTH = 128;
  localparam int TX_DEPTH = 256;
  localparam int PKT_BYTES = 64;
  localparam logic [7:0] TMO_RESET_MS = 8'h10;
  localparam logic [7:0] TMO_MIN_MS = 8'h02;
  localparam logic [7:0] WAKE_MS = 8'h14;
  localparam logic [15:0] BB_DIV_RESET = 16'h0010;
  localparam logic [7:0] PIN_RESET = 8'h00;
  // pin slots inside the synchroniser word
  localparam int SY_DATA_LSB = 0;
  localparam int SY_RST_N = 8;
  localparam int SY_WAKE_N = 9;
  localparam int SY_WR = 10;
  localparam int SY_RD_N = 11;
  localparam int SY_W = 12;
  localparam logic [SY_W-1:0] SY_RESET = 12'hb00;
  typedef enum logic [1:0] {
    UPFC_MODE_FIFO = 2'b00,
    UPFC_MODE_ASYNC_BB = 2'b01,
    UPFC_MODE_SYNC_BB = 2'b11
  } upfc_mode_t;
endpackage

// ==== design/upfc_fifo_if.sv ====
interface upfc_fifo_if #(
  parameter int W = 8,
  parameter int DEPTH = 128
);
  localparam int CW = $clog2(DEPTH + 1);
  logic push;
  logic [W-1:0] push_data;
  logic room;
  logic pop;
  logic [W-1:0] pop_data;
  logic avail;
  logic [CW-1:0] count;
  modport store (
    input push, push_data, pop,
    output room, pop_data, avail, count
  );
  modport user (
    output push, push_data, pop,
    input room, pop_data, avail, count
  );
endinterface

// ==== design/upfc_fifo.sv ====
module upfc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 128
) (
  input wire logic clk_i,
  input wire logic rst_i,
  upfc_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("upfc_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic do_push;
  logic do_pop;

  assign do_push = f.push && f.room;
  assign do_pop = f.pop && f.avail;
  assign f.room = count_r != CW'(DEPTH);
  assign f.avail = count_r != '0;
  assign f.pop_data = mem[rd_ptr_r];
  assign f.count = count_r;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr_r] <= f.push_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + CW'(1);
      end else if (do_pop && !do_push) begin
        count_r <= count_r - CW'(1);
      end
    end
  end
endmodule

// ==== design/usb_parallel_fifo_ctrl.sv ====
module usb_parallel_fifo_ctrl #(
  parameter int MS_CYCLES = upfc_pkg::MS_CYCLES,
  parameter int RX_DEPTH = upfc_pkg::RX_DEPTH,
  parameter int TX_DEPTH = upfc_pkg::TX_DEPTH,
  parameter int PKT_BYTES = upfc_pkg::PKT_BYTES,
  parameter logic WAKE_EN_DEFAULT = 1'b1,
  // identity value is arbitrary
  parameter logic [63:0] CHIP_ID = 64'h5a5a_0000_1234_abcd
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_reset_n_i,
  input wire logic usb_out_valid_i,
  input wire logic [7:0] usb_out_data_i,
  output logic usb_out_ready_o,
  output logic usb_in_valid_o,
  output logic [7:0] usb_in_data_o,
  input wire logic usb_in_ready_i,
  input wire logic usb_suspend_i,
  input wire logic cfg_wake_en_i,
  input wire logic cfg_wake_en_load_i,
  input wire upfc_pkg::upfc_mode_t cfg_mode_i,
  input wire logic [7:0] cfg_bb_dir_i,
  input wire logic [15:0] cfg_bb_div_i,
  input wire logic [7:0] cfg_tmo_ms_i,
  input wire logic cfg_tmo_load_i,
  input wire logic [7:0] parallel_data_bus_i,
  output logic [7:0] parallel_data_bus_o,
  output logic [7:0] parallel_data_bus_oe_o,
  input wire logic rd_n_i,
  input wire logic wr_i,
  input wire logic rx_data_available_n_i,
  output logic rx_data_available_n_o,
  output logic rx_data_available_n_oe_o,
  output logic tx_space_available_n_o,
  output logic tx_space_available_n_oe_o,
  output logic resume_req_o,
  output logic [63:0] chip_id_o
);
  localparam int MSW = $clog2(MS_CYCLES);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TCW = $clog2(TX_DEPTH + 1);

  if (MS_CYCLES < 2 || PKT_BYTES < 1 || PKT_BYTES > TX_DEPTH ||
      RX_DEPTH < 4 || TX_DEPTH < 4) begin : g_chk
    $error("usb_parallel_fifo_ctrl parameters out of range");
  end

  logic rst_c;
  upfc_fifo_if #(.W(8), .DEPTH(RX_DEPTH)) rx_if ();
  upfc_fifo_if #(.W(8), .DEPTH(TX_DEPTH)) tx_if ();

  upfc_fifo #(.W(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_c),
    .f(rx_if.store)
  );

  upfc_fifo #(.W(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_c),
    .f(tx_if.store)
  );

  logic [upfc_pkg::SY_W-1:0] sy1_r;
  logic [upfc_pkg::SY_W-1:0] sy2_r;
  logic rd_d_r;
  logic wr_d_r;
  logic rd_fall;
  logic wr_fall;
  logic [7:0] pins_s;
  logic mode_fifo;
  logic mode_async;
  logic mode_sync;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic [MSW-1:0] ms_cnt_r;
  logic ms_tick;
  logic [15:0] bb_cnt_r;
  logic bb_tick;
  logic [7:0] tmo_ms_r;
  logic [7:0] age_ms_r;
  logic flush_r;
  logic in_allow;
  logic wake_en_r;
  logic wake_mode;
  logic [7:0] low_ms_r;
  logic wake_sent_r;
  logic out_ready_r;
  logic in_valid_r;
  logic [7:0] in_data_r;
  logic [7:0] pdata_r;
  logic [7:0] pdata_oe_r;
  logic rxf_n_r;
  logic rxf_oe_r;
  logic txe_n_r;
  logic txe_oe_r;
  logic resume_r;
  logic [63:0] chip_id_r;

  // two-stage synchroniser for every pin input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy1_r <= upfc_pkg::SY_RESET;
      sy2_r <= upfc_pkg::SY_RESET;
    end else begin
      sy1_r <= {rd_n_i, wr_i, rx_data_available_n_i, ext_reset_n_i,
                parallel_data_bus_i};
      sy2_r <= sy1_r;
    end
  end

  // internal reset from power-up reset or external reset pin
  assign rst_c = rst_i || !sy2_r[upfc_pkg::SY_RST_N];
  assign pins_s = sy2_r[upfc_pkg::SY_DATA_LSB +: 8];
  assign mode_fifo = cfg_mode_i == upfc_pkg::UPFC_MODE_FIFO;
  assign mode_async = cfg_mode_i == upfc_pkg::UPFC_MODE_ASYNC_BB;
  assign mode_sync = cfg_mode_i == upfc_pkg::UPFC_MODE_SYNC_BB;

  // strobe edges seen only on synchronised copies
  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b0;
    end else begin
      rd_d_r <= sy2_r[upfc_pkg::SY_RD_N];
      wr_d_r <= sy2_r[upfc_pkg::SY_WR];
    end
  end
  assign rd_fall = rd_d_r && !sy2_r[upfc_pkg::SY_RD_N];
  assign wr_fall = wr_d_r && !sy2_r[upfc_pkg::SY_WR];

  // millisecond tick derived from the controller clock
  always_ff @(posedge clk_i) begin
    if (rst_c || ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + MSW'(1);
    end
  end
  assign ms_tick = ms_cnt_r == MSW'(MS_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    if (rst_c || bb_tick) begin
      bb_cnt_r <= rst_c ? upfc_pkg::BB_DIV_RESET : cfg_bb_div_i;
    end else begin
      bb_cnt_r <= bb_cnt_r - 16'h0001;
    end
  end
  assign bb_tick = bb_cnt_r == 16'h0000;

  // read strobe pops in fifo mode; tick pops in async mode
  // sync mode pops only while the sample has room
  always_comb begin
    rx_pop = 1'b0;
    if (mode_fifo) begin
      rx_pop = rd_fall && rx_if.avail;
    end else if (mode_async) begin
      rx_pop = bb_tick && rx_if.avail;
    end else if (mode_sync) begin
      rx_pop = bb_tick && rx_if.avail && tx_if.room;
    end
  end

  // write strobe captures; sync mode samples pins per output
  assign tx_push = mode_fifo ? wr_fall : (mode_sync && rx_pop);
  assign rx_if.pop = rx_pop;
  assign rx_if.push = usb_out_valid_i && out_ready_r;
  assign rx_if.push_data = usb_out_data_i;
  assign tx_if.push = tx_push;
  assign tx_if.push_data = pins_s;

  // bytes arrive already recovered and checked
  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      out_ready_r <= 1'b0;
    end else begin
      out_ready_r <= rx_if.count < RCW'(RX_DEPTH - 2);
    end
  end

  // data lines: strobe-gated drive or general I/O port
  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      pdata_r <= upfc_pkg::PIN_RESET;
      pdata_oe_r <= 8'h00;
    end else begin
      if (rx_pop) begin
        pdata_r <= rx_if.pop_data;
      end
      if (mode_fifo) begin
        // drive only while read strobe stays low
        pdata_oe_r <= {8{!sy2_r[upfc_pkg::SY_RD_N]}};
      end else begin
        pdata_oe_r <= cfg_bb_dir_i;
      end
    end
  end

  // timeout register, clamped to the legal range
  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      tmo_ms_r <= upfc_pkg::TMO_RESET_MS;
    end else if (cfg_tmo_load_i) begin
      tmo_ms_r <= (cfg_tmo_ms_i < upfc_pkg::TMO_MIN_MS) ?
                  upfc_pkg::TMO_MIN_MS : cfg_tmo_ms_i;
    end
  end

  // partial data ages; flush once the timeout expires
  always_ff @(posedge clk_i) begin
    if (rst_c || tx_push || !tx_if.avail) begin
      age_ms_r <= 8'h00;
    end else if (ms_tick && age_ms_r != 8'hff) begin
      age_ms_r <= age_ms_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      flush_r <= 1'b0;
    end else if (tx_if.avail && age_ms_r >= tmo_ms_r) begin
      flush_r <= 1'b1;
    end else if (!tx_if.avail) begin
      flush_r <= 1'b0;
    end
  end

  // IN stage: bytes while a full packet is queued, or anything once flushed
  assign in_allow = tx_if.count >= TCW'(PKT_BYTES) || flush_r;
  assign tx_pop = (!in_valid_r || usb_in_ready_i) && tx_if.avail && in_allow;
  assign tx_if.pop = tx_pop;

  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      in_valid_r <= 1'b0;
      in_data_r <= 8'h00;
    end else if (!in_valid_r || usb_in_ready_i) begin
      in_valid_r <= tx_pop;
      if (tx_pop) begin
        in_data_r <= tx_if.pop_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      wake_en_r <= WAKE_EN_DEFAULT;
    end else if (cfg_wake_en_load_i) begin
      wake_en_r <= cfg_wake_en_i;
    end
  end
  assign wake_mode = usb_suspend_i && wake_en_r;

  // count whole milliseconds of low wake pin
  always_ff @(posedge clk_i) begin
    if (rst_c || !wake_mode || sy2_r[upfc_pkg::SY_WAKE_N]) begin
      low_ms_r <= 8'h00;
    end else if (ms_tick && low_ms_r != upfc_pkg::WAKE_MS) begin
      low_ms_r <= low_ms_r + 8'h01;
    end
  end

  // one resume request per low hold
  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      resume_r <= 1'b0;
      wake_sent_r <= 1'b0;
    end else begin
      resume_r <= 1'b0;
      if (low_ms_r == 8'h00) begin
        wake_sent_r <= 1'b0;
      end else if (low_ms_r == upfc_pkg::WAKE_MS && !wake_sent_r) begin
        resume_r <= 1'b1;
        wake_sent_r <= 1'b1;
      end
    end
  end

  // handshake flags; pin released in wake mode
  always_ff @(posedge clk_i) begin
    if (rst_c) begin
      rxf_n_r <= 1'b1;
      txe_n_r <= 1'b1;
      rxf_oe_r <= 1'b0;
      txe_oe_r <= 1'b0;
    end else begin
      rxf_n_r <= !(mode_fifo && rx_if.count > RCW'(rx_pop));
      txe_n_r <= !(mode_fifo && tx_if.count < TCW'(TX_DEPTH - 2));
      rxf_oe_r <= !wake_mode;
      txe_oe_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    chip_id_r <= CHIP_ID;
  end

  assign usb_out_ready_o = out_ready_r;
  assign usb_in_valid_o = in_valid_r;
  assign usb_in_data_o = in_data_r;
  assign parallel_data_bus_o = pdata_r;
  assign parallel_data_bus_oe_o = pdata_oe_r;
  assign rx_data_available_n_o = rxf_n_r;
  assign rx_data_available_n_oe_o = rxf_oe_r;
  assign tx_space_available_n_o = txe_n_r;
  assign tx_space_available_n_oe_o = txe_oe_r;
  assign resume_req_o = resume_r;
  assign chip_id_o = chip_id_r;
endmodule

// ==== tb/upfc_chk.sv ====
module upfc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire upfc_pkg::upfc_mode_t cfg_mode_i,
  input wire logic [7:0] cfg_bb_dir_i,
  input wire logic usb_out_valid_i,
  input wire logic usb_out_ready_o,
  input wire logic usb_in_valid_o,
  input wire logic [7:0] usb_in_data_o,
  input wire logic usb_in_ready_i,
  input wire logic usb_suspend_i,
  input wire logic rd_n_i,
  input wire logic [7:0] parallel_data_bus_oe_o,
  input wire logic rx_data_available_n_o,
  input wire logic rx_data_available_n_oe_o,
  input wire logic tx_space_available_n_o,
  input wire logic tx_space_available_n_oe_o,
  input wire logic resume_req_o
);
  localparam upfc_pkg::upfc_mode_t MD_FIFO = upfc_pkg::UPFC_MODE_FIFO;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !tx_space_available_n_oe_o && !resume_req_o && !usb_in_valid_o)
    else $error("outputs active in reset");
  a_resume_single: assert property (resume_req_o |=> !resume_req_o)
    else $error("resume pulse too long");
  a_resume_pin_in: assert property (resume_req_o |-> usb_suspend_i &&
    !rx_data_available_n_oe_o) else $error("resume outside suspend");
  a_in_byte_hold: assert property (usb_in_valid_o && !usb_in_ready_i |=>
    usb_in_valid_o && $stable(usb_in_data_o)) else $error("in byte lost");
  a_rxf_on_push: assert property (rd_n_i [*3] ##0 (usb_out_valid_i &&
    usb_out_ready_o && cfg_mode_i == MD_FIFO) ##1 (cfg_mode_i == MD_FIFO)
    |=> !rx_data_available_n_o) else $error("data flag not low");
  a_txe_bb_high: assert property (cfg_mode_i[0] [*2] |->
    tx_space_available_n_o) else $error("write allowed in bit-bang");
  a_bb_pin_dir: assert property ((cfg_mode_i ==
    upfc_pkg::UPFC_MODE_ASYNC_BB && $stable(cfg_bb_dir_i)) [*2] |->
    parallel_data_bus_oe_o == cfg_bb_dir_i) else $error("pin dir wrong");
  a_idle_no_drive: assert property ((cfg_mode_i == MD_FIFO && rd_n_i) [*6]
    |-> parallel_data_bus_oe_o == 8'h00) else $error("bus driven idle");
  a_read_drives: assert property ($fell(rd_n_i) &&
    !rx_data_available_n_o && cfg_mode_i == MD_FIFO |->
    ##[2:6] parallel_data_bus_oe_o == 8'hff) else $error("read not driven");
  c_in_taken: cover property (usb_in_valid_o && usb_in_ready_i);
  c_refused: cover property (usb_out_valid_i && !usb_out_ready_o);
  c_resume: cover property (resume_req_o);
  c_sync_in: cover property (usb_in_valid_o &&
    cfg_mode_i == upfc_pkg::UPFC_MODE_SYNC_BB);
endmodule

bind usb_parallel_fifo_ctrl upfc_chk i_chk (.clk_i, .rst_i, .cfg_mode_i,
  .cfg_bb_dir_i, .usb_out_valid_i, .usb_out_ready_o, .usb_in_valid_o,
  .usb_in_data_o, .usb_in_ready_i, .usb_suspend_i, .rd_n_i,
  .parallel_data_bus_oe_o, .rx_data_available_n_o,
  .rx_data_available_n_oe_o, .tx_space_available_n_o,
  .tx_space_available_n_oe_o, .resume_req_o);

// ==== tb/upfc_ext_model.sv ====
module upfc_ext_model (
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  input wire logic rxf_n_i,
  input wire logic txe_n_i,
  output logic rd_n_o,
  output logic wr_o,
  output logic [7:0] drv_o,
  output logic drv_en_o,
  output logic wake_n_o,
  output logic got_o,
  output logic [7:0] got_d_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rd_n_o = 1'b1;
    wr_o = 1'b0;
    drv_o = 8'h00;
    drv_en_o = 1'b0;
    wake_n_o = 1'b1;
    got_o = 1'b0;
    got_d_o = 8'h00;
  end
  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic write_byte(logic [7:0] d, int gap);
    repeat (2000) if (txe_n_i !== 1'b0) step(1);
    drv_o = d;
    drv_en_o = 1'b1;
    wr_o = 1'b1;
    step(4);
    wr_o = 1'b0;
    step(4);
    drv_en_o = 1'b0;
    step(gap);
  endtask
  task automatic read_byte(int gap);
    repeat (2000) if (rxf_n_i !== 1'b0) step(1);
    rd_n_o = 1'b0;
    step(6);
    got_d_o = bus_i;
    got_o = 1'b1;
    step(1);
    got_o = 1'b0;
    rd_n_o = 1'b1;
    step(5 + gap);
  endtask
  task automatic wake(int n);
    wake_n_o = 1'b0;
    step(n);
    wake_n_o = 1'b1;
  endtask
endmodule

// ==== tb/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MSC = 50;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic usb_in_ready_i = 1'b0;
  logic usb_out_valid_i, usb_out_ready_o, usb_in_valid_o, usb_suspend_i;
  logic cfg_wake_en_i, cfg_wake_en_load_i, cfg_tmo_load_i, rd_n_i, wr_i;
  logic rx_data_available_n_i, rx_data_available_n_o, resume_req_o;
  logic rx_data_available_n_oe_o, tx_space_available_n_o;
  logic tx_space_available_n_oe_o, drv_en, wake_n, got, in_en, ok;
  logic ext_reset_n_i = 1'b1;
  logic [63:0] chip_id_o;
  // arbitrary identity value
  localparam logic [63:0] CHIP_ID_V = 64'h0123_4567_89ab_cdef;
  logic [7:0] usb_out_data_i, usb_in_data_o, cfg_bb_dir_i, cfg_tmo_ms_i;
  logic [7:0] parallel_data_bus_i, parallel_data_bus_o, drv, got_d;
  logic [7:0] parallel_data_bus_oe_o;
  logic [7:0] tmo_tab[3] = '{8'h10, 8'h01, 8'hff};
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  logic [31:0] seed = 32'h4152ff59;
  upfc_pkg::upfc_mode_t cfg_mode_i;
  int mismatches, samples_checked, n, e, n_res;
  usb_parallel_fifo_ctrl #(.MS_CYCLES(MSC), .CHIP_ID(CHIP_ID_V)) i_dut (
    .clk_i, .rst_i, .ext_reset_n_i, .usb_out_valid_i, .usb_out_data_i,
    .usb_out_ready_o, .usb_in_valid_o, .usb_in_data_o, .usb_in_ready_i,
    .usb_suspend_i, .cfg_wake_en_i, .cfg_wake_en_load_i, .cfg_mode_i,
    .cfg_bb_dir_i, .cfg_bb_div_i(16'h0007), .cfg_tmo_ms_i, .cfg_tmo_load_i,
    .parallel_data_bus_i, .parallel_data_bus_o, .parallel_data_bus_oe_o,
    .rd_n_i, .wr_i, .rx_data_available_n_i, .rx_data_available_n_o,
    .rx_data_available_n_oe_o, .tx_space_available_n_o,
    .tx_space_available_n_oe_o, .resume_req_o, .chip_id_o);
  upfc_ext_model i_ext (.clk_i, .bus_i(parallel_data_bus_i),
    .rxf_n_i(rx_data_available_n_o), .txe_n_i(tx_space_available_n_o),
    .rd_n_o(rd_n_i), .wr_o(wr_i), .drv_o(drv), .drv_en_o(drv_en),
    .wake_n_o(wake_n), .got_o(got), .got_d_o(got_d));
  // released data lines sit at their pull-up level
  assign parallel_data_bus_i = (parallel_data_bus_oe_o & parallel_data_bus_o)
    | (~parallel_data_bus_oe_o & (drv_en ? drv : 8'hff));
  assign rx_data_available_n_i = rx_data_available_n_oe_o ?
    rx_data_available_n_o : wake_n;
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] xs(logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  always @(posedge clk_i) begin
    #1;
    seed = xs(seed);
    usb_in_ready_i = in_en & seed[0];
  end
  task automatic step(int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic check(string nm, logic [31:0] x, logic [31:0] s);
    samples_checked++;
    if (s !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  always @(posedge clk_i) begin
    if (usb_in_valid_o === 1'b1 && usb_in_ready_i === 1'b1)
      check("in byte", txq.pop_front(), usb_in_data_o);
    if (got === 1'b1)
      check("read byte", rxq.pop_front(), got_d);
    if (resume_req_o === 1'b1)
      n_res++;
  end
  task automatic host_out(logic [7:0] v, output logic acc);
    usb_out_valid_i = 1'b1;
    usb_out_data_i = v;
    @(posedge clk_i);
    acc = usb_out_ready_o;
    if (acc === 1'b1)
      rxq.push_back(v);
    #1;
  endtask
  task automatic put();
    logic [7:0] v;
    v = seed[15:8];
    txq.push_back(v);
    i_ext.write_byte(v, 0);
  endtask
  task automatic drain();
    in_en = 1'b1;
    repeat (14000) if (txq.size() != 0) step(1);
    check("tx drained", 0, txq.size());
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #600000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {usb_out_valid_i, usb_suspend_i, cfg_wake_en_load_i} = 3'b000;
    {cfg_tmo_load_i, in_en, usb_out_data_i} = 10'h000;
    cfg_wake_en_i = 1'b1;
    cfg_mode_i = upfc_pkg::UPFC_MODE_FIFO;
    cfg_bb_dir_i = 8'hff;
    cfg_tmo_ms_i = 8'h10;
    step(20);
    rst_i = 1'b0;
    step(3);
    n = 0;
    repeat (130) begin
      host_out(seed[15:8], ok);
      n += ok;
    end
    usb_out_valid_i = 1'b0;
    check("accepted", upfc_pkg::RX_DEPTH - 1, n);
    repeat (upfc_pkg::RX_DEPTH - 1) i_ext.read_byte(0);
    check("rxf empty", 1, rx_data_available_n_o);
    foreach (tmo_tab[j]) begin
      cfg_tmo_ms_i = tmo_tab[j];
      cfg_tmo_load_i = (j != 0);
      step(1);
      cfg_tmo_load_i = 1'b0;
      repeat (3) put();
      n = 0;
      while (usb_in_valid_o !== 1'b1 && n < 14000) begin
        step(1);
        n++;
      end
      e = (tmo_tab[j] < 2) ? 2 : tmo_tab[j];
      check("flush", 1, n >= (e - 1) * MSC && n <= (e + 1) * MSC);
      drain();
    end
    in_en = 1'b0;
    repeat (upfc_pkg::TX_DEPTH - 1) put();
    step(2);
    check("tx full", 1, tx_space_available_n_o);
    drain();
    usb_suspend_i = 1'b1;
    step(3);
    check("pin input", 0, rx_data_available_n_oe_o);
    i_ext.wake(15 * MSC);
    step(5);
    check("short wake", 0, n_res);
    i_ext.wake(21 * MSC);
    step(5);
    check("resume", 1, n_res);
    cfg_wake_en_i = 1'b0;
    cfg_wake_en_load_i = 1'b1;
    step(1);
    cfg_wake_en_load_i = 1'b0;
    step(3);
    check("pin output", 1, rx_data_available_n_oe_o);
    usb_suspend_i = 1'b0;
    cfg_mode_i = upfc_pkg::UPFC_MODE_ASYNC_BB;
    step(3);
    repeat (4) host_out(seed[15:8], ok);
    usb_out_valid_i = 1'b0;
    repeat (4) begin
      n = 0;
      while (parallel_data_bus_o !== rxq[0] && n < 20) begin
        step(1);
        n++;
      end
      check("bb out", rxq.pop_front(), parallel_data_bus_o);
    end
    check("bb dir", 8'hff, parallel_data_bus_oe_o);
    cfg_mode_i = upfc_pkg::UPFC_MODE_SYNC_BB;
    cfg_bb_dir_i = 8'h00;
    cfg_tmo_ms_i = 8'h02;
    cfg_tmo_load_i = 1'b1;
    step(1);
    cfg_tmo_load_i = 1'b0;
    step(3);
    repeat (4) begin
      host_out(seed[15:8], ok);
      txq.push_back(8'hff);
    end
    usb_out_valid_i = 1'b0;
    drain();
    check("chip id", 1, chip_id_o === CHIP_ID_V);
    ext_reset_n_i = 1'b0;
    step(4);
    check("reset txe oe", 0, tx_space_available_n_oe_o);
    ext_reset_n_i = 1'b1;
    step(4);
    check("run txe oe", 1, tx_space_available_n_oe_o);
    report_and_stop();
  end
endmodule
